// ==== core/pcowp_qual_timer.sv ====
// Purpose: qualify one current fault over a scaled 10-bit delay
// Assumes: over_i is synchronous to clk_i
// Notes:   count restarts whenever the condition drops
`timescale 1ns/1ps
module pcowp_qual_timer (
  input  wire logic  clk_i,
  input  wire logic  reset_i,
  pcowp_tick_if.dst  tick,
  input  wire logic  over_i,
  input  wire logic [11:0] cfg_i,
  output logic       hit_o
);
  logic [9:0] cnt_q;
  logic       unit;

  always_comb begin
    unique case (cfg_i[pcowp_pkg::DLY_SCALE +: 2])
      2'b00: unit = tick.us_tick;
      2'b01: unit = tick.ms_tick;
      2'b10: unit = tick.s_tick;
      2'b11: unit = tick.min_tick;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 10'h000;
    end else if (!over_i) begin
      cnt_q <= 10'h000;
    end else if (unit && cnt_q != cfg_i[9:0]) begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  // zero delay qualifies on the first sample over threshold
  assign hit_o = over_i && (cnt_q == cfg_i[9:0]);

  a_restart_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    !over_i |=> cnt_q == 10'h000) else $error("qual count not restarted");
endmodule : pcowp_qual_timer

// ==== core/pcowp_top.sv ====
// Purpose: pack current and open-wire protection logic
// Assumes: cell codes and sense voltages are sampled on clk_i by the analog front end
// Notes:   sense voltages are magnitudes in mV, integer part
// Overview of operation
// - after each open-wire test, any cell code at min or max flags open wire
// - open wire with shutdown select 0 turns off FETs, pack-disable stays off
// - with shutdown select 0 scanning, current monitor and mode stepping continue
// - open wire with shutdown select 1 flags, turns off FETs, drives pack-disable
// - a later clean test resets open-wire flag; other checks gate FETs
// - open-wire test runs on the scan after cell fail was raised
// - current monitor runs in all modes except sleep
// - three thresholds compared; action only after each qualifying duration
// - charge-present or discharge-present flag follows detected direction
// - two-bit gain select picks x5, x50 or x500
// - store offset-corrected 14-bit result and 12-bit comparison value
// - readout spans 250, 25 or 2.5 mV per gain
// - fault path runs in all modes except sleep and chooses its own gain
// - direction state entered and left only after 2 ms persistence
// - discharge overcurrent codes map to 4 through 96 mV
// - charge overcurrent codes map to 1 through 24 mV
// - short-circuit codes map to 16 through 256 mV
// - each fault has 10-bit count and 2-bit scale delay
// - scale selects microseconds, milliseconds, seconds or minutes
// - scans repeat every 32, 256 or 512 ms by mode
// - test on cell-fail onset then every 32 scans; disable bit suppresses
// - cell fail when max-min spread exceeds delta limit; all ones disables
// - qualified overcurrent turns power FET off unless override; short always turns power FET off
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module pcowp_top #(
  parameter int unsigned NCELL     = 8,
  parameter int unsigned MS_CYCLES = 10_000
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [3:0]       addr_i,
  input  wire logic [15:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [15:0]      rdata_o,
  input  wire logic [NCELL*12-1:0] cell_code_i,
  input  wire logic [8:0]       sense_mv_i,
  input  wire logic             sense_dsg_i,
  input  wire logic             sense_chg_i,
  input  wire logic [13:0]      cur_raw_i,
  input  wire logic             cur_valid_i,
  output logic                  power_fet_on_o,
  output logic                  balance_fet_on_o,
  output logic                  pack_disable_output_o,
  output logic                  monitor_active_o,
  output logic                  scan_strobe_o,
  output logic                  ow_test_o,
  output logic [1:0]            fault_gain_o
);
  // sense voltage and direction pins from the analog side pass two flops
  logic [8:0] smv_m, smv_s;
  logic [1:0] dir_m, dir_s;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      smv_m <= 9'h000;
      smv_s <= 9'h000;
      dir_m <= 2'b00;
      dir_s <= 2'b00;
    end else begin
      smv_m <= sense_mv_i;
      smv_s <= smv_m;
      dir_m <= {sense_dsg_i, sense_chg_i};
      dir_s <= dir_m;
    end
  end

  // registers
  logic [15:0] ctrl_q, ocd_q, occ_q, sc_q;
  logic [11:0] delta_q;
  logic [13:0] cal_q;
  logic        clr_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q  <= pcowp_pkg::CTRL_RST;
      ocd_q   <= pcowp_pkg::DLY_CFG_RST;
      occ_q   <= pcowp_pkg::DLY_CFG_RST;
      sc_q    <= pcowp_pkg::DLY_CFG_RST;
      delta_q <= pcowp_pkg::DELTA_RST;
      cal_q   <= 14'h0000;
      clr_q   <= 1'b0;
    end else begin
      clr_q <= wr_i && addr_i == pcowp_pkg::REG_FLT_CLR;
      if (wr_i) begin
        unique case (addr_i)
          pcowp_pkg::REG_CTRL:    ctrl_q  <= wdata_i;
          pcowp_pkg::REG_OCD_CFG: ocd_q   <= {4'h0, wdata_i[11:0]};
          pcowp_pkg::REG_OCC_CFG: occ_q   <= {4'h0, wdata_i[11:0]};
          pcowp_pkg::REG_SC_CFG:  sc_q    <= {4'h0, wdata_i[11:0]};
          pcowp_pkg::REG_DELTA:   delta_q <= wdata_i[11:0];
          pcowp_pkg::REG_CAL:     cal_q   <= wdata_i[13:0];
          default: ;
        endcase
      end
    end
  end

  logic        open_wire_shutdown_select, owdis, hfo;
  logic [1:0]  gain_sel;
  pcowp_pkg::pcowp_mode_t mode;
  assign open_wire_shutdown_select    = ctrl_q[pcowp_pkg::CTRL_OPEN_WIRE_SHUTDOWN_SELECT];
  assign owdis    = ctrl_q[pcowp_pkg::CTRL_OWDIS];
  assign hfo      = ctrl_q[pcowp_pkg::CTRL_HFO];
  assign gain_sel = ctrl_q[pcowp_pkg::CTRL_GAIN +: 2];
  assign mode     = pcowp_pkg::pcowp_mode_t'(ctrl_q[pcowp_pkg::CTRL_MODE +: 2]);

  // time base
  pcowp_tick_if tick ();
  logic [9:0]  us_pre_q;
  logic [31:0] ms_pre_q;
  logic [9:0]  s_pre_q;
  logic [5:0]  min_pre_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      us_pre_q  <= 10'h000;
      ms_pre_q  <= 32'h0000_0000;
      s_pre_q   <= 10'h000;
      min_pre_q <= 6'h00;
    end else begin
      us_pre_q <= (us_pre_q == 10'(pcowp_pkg::US_CYCLES - 1)) ? 10'h000 : us_pre_q + 10'h001;
      ms_pre_q <= (ms_pre_q == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : ms_pre_q + 32'h0000_0001;
      if (tick.ms_tick) s_pre_q <= (s_pre_q == 10'h3E7) ? 10'h000 : s_pre_q + 10'h001;
      if (tick.s_tick) min_pre_q <= (min_pre_q == 6'h3B) ? 6'h00 : min_pre_q + 6'h01;
    end
  end
  assign tick.us_tick  = us_pre_q == 10'(pcowp_pkg::US_CYCLES - 1);
  assign tick.ms_tick  = ms_pre_q == 32'(MS_CYCLES - 1);
  assign tick.s_tick   = tick.ms_tick && s_pre_q == 10'h3E7;
  assign tick.min_tick = tick.s_tick && min_pre_q == 6'h3B;

  // scan timer; sleep stops scanning
  logic [9:0] scan_ms_q, scan_len;
  logic       scan_p;
  always_comb begin
    unique case (mode)
      pcowp_pkg::PCOWP_NORMAL: scan_len = 10'(pcowp_pkg::SCAN_NORMAL_MS);
      pcowp_pkg::PCOWP_IDLE:   scan_len = 10'(pcowp_pkg::SCAN_IDLE_MS);
      pcowp_pkg::PCOWP_DOZE:   scan_len = 10'(pcowp_pkg::SCAN_DOZE_MS);
      pcowp_pkg::PCOWP_SLEEP:  scan_len = 10'h000;
    endcase
  end
  assign scan_p = tick.ms_tick && scan_len != 10'h000 && scan_ms_q >= scan_len - 10'h001;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) scan_ms_q <= 10'h000;
    else if (scan_p) scan_ms_q <= 10'h000;
    else if (tick.ms_tick) scan_ms_q <= scan_ms_q + 10'h001;
  end

  // cell spread and end-of-test extreme check
  logic [11:0] cmax, cmin;
  logic        any_ext, spread_hi;
  always_comb begin
    cmax = 12'h000;
    cmin = 12'hFFF;
    any_ext = 1'b0;
    for (int i = 0; i < NCELL; i++) begin
      if (cell_code_i[i*12 +: 12] > cmax) cmax = cell_code_i[i*12 +: 12];
      if (cell_code_i[i*12 +: 12] < cmin) cmin = cell_code_i[i*12 +: 12];
      if (cell_code_i[i*12 +: 12] == pcowp_pkg::ADC_MIN_CODE ||
          cell_code_i[i*12 +: 12] == pcowp_pkg::ADC_MAX_CODE) any_ext = 1'b1;
    end
    // all-ones limit can never be exceeded
    spread_hi = (cmax - cmin) > delta_q;
  end

  logic       cell_fail_flag_q, ow_q, ow_pend_q, ow_test_q;
  logic [4:0] ow_scan_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cell_fail_flag_q   <= 1'b0;
      ow_pend_q <= 1'b0;
      ow_test_q <= 1'b0;
      ow_scan_q <= 5'h00;
      ow_q      <= 1'b0;
    end else begin
      ow_test_q <= 1'b0;
      if (scan_p) begin
        cell_fail_flag_q <= spread_hi;
        // a test rides the scan after cell fail first shows
        if (ow_pend_q && !owdis) begin
          ow_test_q <= 1'b1;
          ow_pend_q <= 1'b0;
        end
        if (spread_hi && !owdis) begin
          if (!cell_fail_flag_q || ow_scan_q == 5'(pcowp_pkg::OW_SCAN_PERIOD - 1)) ow_pend_q <= 1'b1;
          ow_scan_q <= (!cell_fail_flag_q) ? 5'h00 : ow_scan_q + 5'h01;
        end else if (!spread_hi) begin
          ow_scan_q <= 5'h00;
        end
      end
      if (ow_test_q) ow_q <= any_ext;
    end
  end

  // pack-disable latches; only reset clears it, as it may blow a fuse
  logic psd_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) psd_q <= 1'b0;
    else if (ow_test_q && any_ext && open_wire_shutdown_select) psd_q <= 1'b1;
  end

  // current monitor; off in sleep
  logic mon_on;
  assign mon_on = mode != pcowp_pkg::PCOWP_SLEEP;

  logic ov_ocd, ov_occ, ov_sc, hit_ocd, hit_occ, hit_sc;
  assign ov_ocd = mon_on && dir_s[1] && smv_s > pcowp_pkg::pcowp_ocd_mv(ctrl_q[pcowp_pkg::CTRL_SEL +: 3]);
  // charge select top bit is shared with the short-circuit select
  assign ov_occ = mon_on && dir_s[0] &&
                  smv_s > pcowp_pkg::pcowp_occ_mv({ctrl_q[15], ctrl_q[pcowp_pkg::CTRL_OCC +: 2]});
  assign ov_sc  = mon_on && dir_s[1] && smv_s > pcowp_pkg::pcowp_sc_mv({ctrl_q[15], ctrl_q[pcowp_pkg::CTRL_SCS +: 2]});

  pcowp_qual_timer u_q_ocd (.clk_i(clk_i), .reset_i(reset_i), .tick(tick), .over_i(ov_ocd),
                            .cfg_i(ocd_q[11:0]), .hit_o(hit_ocd));
  pcowp_qual_timer u_q_occ (.clk_i(clk_i), .reset_i(reset_i), .tick(tick), .over_i(ov_occ),
                            .cfg_i(occ_q[11:0]), .hit_o(hit_occ));
  pcowp_qual_timer u_q_sc  (.clk_i(clk_i), .reset_i(reset_i), .tick(tick), .over_i(ov_sc),
                            .cfg_i(sc_q[11:0]), .hit_o(hit_sc));

  // fault flags: hardware set beats software clear
  logic doc_q, coc_q, dsc_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      doc_q <= 1'b0;
      coc_q <= 1'b0;
      dsc_q <= 1'b0;
    end else begin
      doc_q <= hit_ocd | (doc_q & ~clr_q);
      coc_q <= hit_occ | (coc_q & ~clr_q);
      dsc_q <= hit_sc  | (dsc_q & ~clr_q);
    end
  end

  // direction debounce
  logic [15:0] dir_cnt_q;
  pcowp_pkg::pcowp_dir_t dir_q, dir_raw;
  assign dir_raw = !mon_on ? pcowp_pkg::PCOWP_DIR_NONE :
                   dir_s == 2'b10 ? pcowp_pkg::PCOWP_DIR_DSG :
                   dir_s == 2'b01 ? pcowp_pkg::PCOWP_DIR_CHG : pcowp_pkg::PCOWP_DIR_NONE;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dir_q     <= pcowp_pkg::PCOWP_DIR_NONE;
      dir_cnt_q <= 16'h0000;
    end else if (dir_raw == dir_q) begin
      dir_cnt_q <= 16'h0000;
    end else if (dir_cnt_q == 16'(pcowp_pkg::DIR_CYCLES - 1)) begin
      dir_q     <= dir_raw;
      dir_cnt_q <= 16'h0000;
    end else begin
      dir_cnt_q <= dir_cnt_q + 16'h0001;
    end
  end

  // measurement results; fault path gain picked from the charge or discharge scale
  logic [13:0] cur_full_q;
  logic [11:0] cur_cmp_q;
  logic [1:0]  fgain_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_full_q <= 14'h0000;
      cur_cmp_q  <= 12'h000;
      fgain_q    <= 2'b00;
    end else begin
      if (cur_valid_i) begin
        cur_full_q <= cur_raw_i - cal_q;
        cur_cmp_q  <= 12'((cur_raw_i - cal_q) >> 2);
      end
      fgain_q <= dir_s[0] ? 2'b01 : 2'b00;
    end
  end

  // outputs
  logic fet_kill;
  assign fet_kill = ow_q || dsc_q || (!hfo && (doc_q || coc_q));
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      power_fet_on_o        <= 1'b0;
      balance_fet_on_o      <= 1'b0;
      pack_disable_output_o <= 1'b0;
      monitor_active_o      <= 1'b0;
      scan_strobe_o         <= 1'b0;
      ow_test_o             <= 1'b0;
      fault_gain_o          <= 2'b00;
      rdata_o               <= 16'h0000;
    end else begin
      power_fet_on_o        <= !fet_kill && !psd_q;
      balance_fet_on_o      <= !ow_q && !cell_fail_flag_q && !psd_q;
      pack_disable_output_o <= psd_q;
      monitor_active_o      <= mon_on;
      scan_strobe_o         <= scan_p;
      ow_test_o             <= ow_test_q;
      fault_gain_o          <= fgain_q;
      rdata_o               <= 16'h0000;
      if (rd_i) begin
        unique case (addr_i)
          pcowp_pkg::REG_CTRL:     rdata_o <= ctrl_q;
          pcowp_pkg::REG_OCD_CFG:  rdata_o <= ocd_q;
          pcowp_pkg::REG_OCC_CFG:  rdata_o <= occ_q;
          pcowp_pkg::REG_SC_CFG:   rdata_o <= sc_q;
          pcowp_pkg::REG_DELTA:    rdata_o <= {4'h0, delta_q};
          pcowp_pkg::REG_STATUS:   rdata_o <= {7'h00, gain_sel, psd_q, dir_q == pcowp_pkg::PCOWP_DIR_DSG,
                                               dir_q == pcowp_pkg::PCOWP_DIR_CHG, dsc_q, coc_q, doc_q, ow_q};
          pcowp_pkg::REG_CUR_FULL: rdata_o <= {2'b00, cur_full_q};
          pcowp_pkg::REG_CUR_CMP:  rdata_o <= {4'h0, cur_cmp_q};
          pcowp_pkg::REG_CAL:      rdata_o <= {2'b00, cal_q};
          default:                 rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  a_ow_fet_off: assert property (@(posedge clk_i) disable iff (reset_i)
    ow_q |=> !power_fet_on_o && !balance_fet_on_o) else $error("fets on during open wire");
  a_psd_on_open_wire_shutdown_select: assert property (@(posedge clk_i) disable iff (reset_i)
    ow_test_q && any_ext && open_wire_shutdown_select |=> ##1 pack_disable_output_o) else $error("pack disable missing");
  a_sc_always_off: assert property (@(posedge clk_i) disable iff (reset_i)
    hit_sc |=> ##1 !power_fet_on_o) else $error("short did not turn fets off");
  a_dir_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    $changed(dir_q) |-> $past(dir_cnt_q) == 16'(pcowp_pkg::DIR_CYCLES - 1)) else $error("direction changed early");
  a_ow_after_test: assert property (@(posedge clk_i) disable iff (reset_i)
    $changed(ow_q) |-> $past(ow_test_q)) else $error("open flag moved without test");
  a_mon_sleep: assert property (@(posedge clk_i) disable iff (reset_i)
    mode == pcowp_pkg::PCOWP_SLEEP |-> !ov_ocd && !ov_occ && !ov_sc) else $error("monitor active in sleep");
  a_test_needs_cf: assert property (@(posedge clk_i) disable iff (reset_i)
    ow_test_q |-> $past(ow_pend_q)) else $error("test without cell fail");
  a_oc_override: assert property (@(posedge clk_i) disable iff (reset_i)
    hfo && !ow_q && !dsc_q && !psd_q && $stable(hfo) |=> power_fet_on_o) else $error("override ignored");
endmodule : pcowp_top

// ==== pkg/pcowp_pkg.sv ====
// Purpose: shared constants for pack current and open-wire protection
// Assumes: 10 MHz clock, register port with one-cycle read latency
// Notes:   all offsets and the ctrl, delay cfg and delta reset values live here
package pcowp_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned US_TIME         = 1;
  localparam int unsigned US_CYCLES       = (CLK_HZ / 1_000_000) * US_TIME;
  localparam int unsigned DIR_MS          = 2;
  localparam int unsigned DIR_CYCLES      = (CLK_HZ / 1000) * DIR_MS;
  localparam int unsigned OW_SCAN_PERIOD  = 32;
  localparam logic [11:0] ADC_MIN_CODE    = 12'h000;
  localparam logic [11:0] ADC_MAX_CODE    = 12'hFFF;
  localparam logic [11:0] DELTA_DISABLE   = 12'hFFF;
  // scan periods in ms per mode
  localparam int unsigned SCAN_NORMAL_MS  = 32;
  localparam int unsigned SCAN_IDLE_MS    = 256;
  localparam int unsigned SCAN_DOZE_MS    = 512;
  // register offsets (word index)
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_OCD_CFG  = 4'h1;
  localparam logic [3:0] REG_OCC_CFG  = 4'h2;
  localparam logic [3:0] REG_SC_CFG   = 4'h3;
  localparam logic [3:0] REG_DELTA    = 4'h4;
  localparam logic [3:0] REG_STATUS   = 4'h5;
  localparam logic [3:0] REG_CUR_FULL = 4'h6;
  localparam logic [3:0] REG_CUR_CMP  = 4'h7;
  localparam logic [3:0] REG_CAL      = 4'h8;
  localparam logic [3:0] REG_FLT_CLR  = 4'h9;
  // reset values
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [15:0] DLY_CFG_RST = 16'h0000;
  localparam logic [11:0] DELTA_RST   = 12'hFFF;
  // ctrl fields
  localparam int unsigned CTRL_OPEN_WIRE_SHUTDOWN_SELECT  = 0;
  localparam int unsigned CTRL_OWDIS  = 1;
  localparam int unsigned CTRL_HFO    = 2;
  localparam int unsigned CTRL_GAIN   = 3;
  localparam int unsigned CTRL_MODE   = 5;
  localparam int unsigned CTRL_SEL    = 8;
  localparam int unsigned CTRL_OCC    = 11;
  localparam int unsigned CTRL_SCS    = 13;
  // delay cfg fields: count [9:0], scale [11:10]
  localparam int unsigned DLY_SCALE   = 10;

  typedef enum logic [1:0] {
    PCOWP_NORMAL = 2'b00,
    PCOWP_IDLE   = 2'b01,
    PCOWP_DOZE   = 2'b10,
    PCOWP_SLEEP  = 2'b11
  } pcowp_mode_t;

  typedef enum logic [1:0] {
    PCOWP_DIR_NONE = 2'b00,
    PCOWP_DIR_CHG  = 2'b01,
    PCOWP_DIR_DSG  = 2'b10
  } pcowp_dir_t;

  // threshold lookups in mV
  function automatic logic [8:0] pcowp_ocd_mv(input logic [2:0] s);
    logic [8:0] r;
    r = 9'h000;
    unique case (s)
      3'h0: r = 9'h004;
      3'h1: r = 9'h008;
      3'h2: r = 9'h010;
      3'h3: r = 9'h018;
      3'h4: r = 9'h020;
      3'h5: r = 9'h030;
      3'h6: r = 9'h040;
      3'h7: r = 9'h060;
    endcase
    return r;
  endfunction : pcowp_ocd_mv

  function automatic logic [8:0] pcowp_occ_mv(input logic [2:0] s);
    logic [8:0] r;
    r = 9'h000;
    unique case (s)
      3'h0: r = 9'h001;
      3'h1: r = 9'h002;
      3'h2: r = 9'h004;
      3'h3: r = 9'h006;
      3'h4: r = 9'h008;
      3'h5: r = 9'h00C;
      3'h6: r = 9'h010;
      3'h7: r = 9'h018;
    endcase
    return r;
  endfunction : pcowp_occ_mv

  function automatic logic [8:0] pcowp_sc_mv(input logic [2:0] s);
    logic [8:0] r;
    r = 9'h000;
    unique case (s)
      3'h0: r = 9'h010;
      3'h1: r = 9'h018;
      3'h2: r = 9'h020;
      3'h3: r = 9'h030;
      3'h4: r = 9'h040;
      3'h5: r = 9'h060;
      3'h6: r = 9'h080;
      3'h7: r = 9'h100;
    endcase
    return r;
  endfunction : pcowp_sc_mv
endpackage : pcowp_pkg

// ==== pkg/pcowp_tick_if.sv ====
// Purpose: time-base ticks shared between top and timer
// Assumes: one clock domain
// Notes:   each tick is a one-cycle pulse
`timescale 1ns/1ps
interface pcowp_tick_if;
  logic us_tick;
  logic ms_tick;
  logic s_tick;
  logic min_tick;
  modport src (output us_tick, output ms_tick, output s_tick, output min_tick);
  modport dst (input us_tick, input ms_tick, input s_tick, input min_tick);
endinterface : pcowp_tick_if

// ==== verif/pcowp_pack_model.sv ====
// Purpose: cells and sense resistor facing the protection block
// Assumes: cell 0 may be opened, the rest sit at one level
// Notes:   no current flows while the power fets are off
`timescale 1ns/1ps
module pcowp_pack_model #(
  parameter int unsigned NCELL = 8
) (
  input  wire logic [11:0]         lvl_i,
  input  wire logic [11:0]         open_i,
  input  wire logic [8:0]          load_mv_i,
  input  wire logic                fet_on_i,
  output logic      [NCELL*12-1:0] cell_code_o,
  output logic      [8:0]          sense_mv_o
);
  always_comb begin
    for (int i = 0; i < NCELL; i++) begin
      cell_code_o[i*12 +: 12] = (i == 0) ? open_i : lvl_i;
    end
  end
  // an open fet path carries no load current, so a fault cannot retrigger itself
  assign sense_mv_o = fet_on_i ? load_mv_i : 9'h000;
endmodule : pcowp_pack_model

// ==== verif/tb_pcowp_top.sv ====
// Purpose: self-checking bench for pack current and open-wire protection
// Assumes: ms tick shortened to 20 cycles, direction debounce stays 20000 cycles
// Notes:   minute scale and doze scan period are not timed, minute scale too long for one run
`timescale 1ns/1ps
module tb_pcowp_top;
  localparam int unsigned NC  = 8;
  localparam int unsigned MSC = 20;
  logic             clk_i    = 1'b0;
  logic             reset_i  = 1'b1;
  logic [3:0]       addr_i   = 4'h0;
  logic [15:0]      wdata_i  = 16'h0000;
  logic             wr_i     = 1'b0;
  logic             rd_i     = 1'b0;
  logic             dsg      = 1'b0;
  logic             chg      = 1'b0;
  logic [11:0]      opn      = 12'h800;
  logic [8:0]       load     = 9'h000;
  logic [13:0]      craw     = 14'h0000;
  logic             cval     = 1'b0;
  logic [15:0]      rdata_o;
  logic [NC*12-1:0] cells;
  logic [8:0]       sense;
  logic             fet_on;
  logic             bal_on;
  logic             pdis;
  logic             mon;
  logic             scan_p;
  logic             ow_p;
  logic [1:0]       fgain;
  logic [15:0]      v;
  int               n;
  int               n_errors = 0;
  int               checked  = 0;
  int               thr[3][8] = '{'{4, 8, 16, 24, 32, 48, 64, 96}, '{1, 2, 4, 6, 8, 12, 16, 24},
                                  '{16, 24, 32, 48, 64, 96, 128, 256}};

  always #50 clk_i = ~clk_i;

  pcowp_top #(.NCELL(NC), .MS_CYCLES(MSC)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .cell_code_i(cells), .sense_mv_i(sense), .sense_dsg_i(dsg), .sense_chg_i(chg),
    .cur_raw_i(craw), .cur_valid_i(cval), .power_fet_on_o(fet_on), .balance_fet_on_o(bal_on),
    .pack_disable_output_o(pdis), .monitor_active_o(mon), .scan_strobe_o(scan_p), .ow_test_o(ow_p),
    .fault_gain_o(fgain));

  pcowp_pack_model #(.NCELL(NC)) pack (
    .lvl_i(12'h800), .open_i(opn), .load_mv_i(load), .fet_on_i(fet_on), .cell_code_o(cells),
    .sense_mv_o(sense));

  task automatic cyc(input int c);
    repeat (c) @(posedge clk_i);
  endtask : cyc

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic ctl(input logic [15:0] d);
    wr(pcowp_pkg::REG_CTRL, d);
  endtask : ctl

  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
    @(posedge clk_i);
  endtask : rd

  task automatic st(input int b, input logic e);
    rd(pcowp_pkg::REG_STATUS);
    chk({15'h0000, v[b]}, {15'h0000, e});
  endtask : st

  // bounded wait for a one-cycle pulse, returns cycles waited
  task automatic pulse(input bit s, input int lim, output int w);
    w = 0;
    do begin
      @(negedge clk_i);
      w++;
    end while ((s ? scan_p : ow_p) !== 1'b1 && w < lim);
    if (w >= lim) n_errors++;
  endtask : pulse

  task automatic rst();
    reset_i <= 1'b1;
    cyc(4);
    reset_i <= 1'b0;
    cyc(5);
  endtask : rst

  function automatic logic [15:0] cfg(input int k, input logic [2:0] c);
    case (k)
      0: return {3'h7, 2'h0, c, 8'h00};
      1: return {c[2], 2'h0, c[1:0], 11'h000};
      default: return {c[2], c[1:0], 2'h0, 3'h7, 8'h00};
    endcase
  endfunction : cfg

  // threshold itself must not trip, one mV above must trip at zero delay
  task automatic faults(input int k);
    for (int c = 0; c < 8; c++) begin
      ctl(cfg(k, c[2:0]));
      load <= 9'(thr[k][c]);
      cyc(8);
      st(k + 1, 1'b0);
      load <= 9'(thr[k][c] + 1);
      cyc(8);
      st(k + 1, 1'b1);
      chk({15'h0000, fet_on}, 16'h0000);
      load <= 9'h000;
      wr(pcowp_pkg::REG_FLT_CLR, 16'h0000);
      cyc(4);
      chk({15'h0000, fet_on}, 16'h0001);
    end
  endtask : faults

  task automatic report_and_stop();
    $display("mismatches %0d of %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    rst();
    chk({15'h0000, fet_on}, 16'h0001);
    rd(pcowp_pkg::REG_CTRL);
    chk(v, pcowp_pkg::CTRL_RST);
    rd(pcowp_pkg::REG_DELTA);
    chk(v, {4'h0, pcowp_pkg::DELTA_RST});
    rd(4'hF);
    chk(v, 16'h0000);
    wr(pcowp_pkg::REG_CAL, 16'h0034);
    craw <= 14'h1234;
    cval <= 1'b1;
    cyc(1);
    cval <= 1'b0;
    rd(pcowp_pkg::REG_CUR_FULL);
    chk(v, 16'h1200);
    rd(pcowp_pkg::REG_CUR_CMP);
    chk(v, 16'h0480);
    for (int m = 0; m < 4; m++) begin
      ctl(16'(m << 5));
      cyc(3);
      chk({15'h0000, mon}, {15'h0000, m != 3});
    end
    for (int g = 0; g < 3; g++) begin
      ctl(16'(g << 3));
      rd(pcowp_pkg::REG_STATUS);
      chk({14'h0000, v[8:7]}, 16'(g));
    end
    for (int m = 1; m >= 0; m--) begin
      ctl(16'(m << 5));
      pulse(1'b1, 12000, n);
      pulse(1'b1, 12000, n);
      chk(16'(n), 16'(MSC * (m ? pcowp_pkg::SCAN_IDLE_MS : pcowp_pkg::SCAN_NORMAL_MS)));
    end
    wr(pcowp_pkg::REG_DELTA, 16'h0010);
    opn <= 12'h000;
    pulse(1'b0, 2000, n);
    cyc(3);
    st(0, 1'b1);
    chk({13'h0000, pdis, bal_on, fet_on}, 16'h0000);
    chk({15'h0000, mon}, 16'h0001);
    // spread stays above the limit so the test keeps repeating
    opn <= 12'h900;
    pulse(1'b0, 22000, n);
    cyc(3);
    st(0, 1'b0);
    rst();
    wr(pcowp_pkg::REG_DELTA, 16'h0010);
    ctl(16'h0001);
    opn <= 12'hFFF;
    pulse(1'b0, 2000, n);
    cyc(3);
    st(0, 1'b1);
    chk({14'h0000, pdis, fet_on}, 16'h0002);
    rst();
    opn <= 12'h800;
    dsg <= 1'b1;
    cyc(19900);
    st(5, 1'b0);
    cyc(200);
    st(5, 1'b1);
    chk({14'h0000, fgain}, 16'h0000);
    faults(0);
    ctl(16'hE004);
    wr(pcowp_pkg::REG_OCD_CFG, 16'h0005);
    load <= 9'h005;
    cyc(35);
    load <= 9'h000;
    cyc(5);
    load <= 9'h005;
    cyc(35);
    st(1, 1'b0);
    cyc(30);
    st(1, 1'b1);
    chk({15'h0000, fet_on}, 16'h0001);
    load <= 9'h000;
    // let the sense path drain so the clear is not beaten by a late hit
    cyc(4);
    wr(pcowp_pkg::REG_FLT_CLR, 16'h0000);
    wr(pcowp_pkg::REG_OCD_CFG, 16'h0403);
    load <= 9'h005;
    cyc(35);
    st(1, 1'b0);
    cyc(35);
    st(1, 1'b1);
    load <= 9'h000;
    cyc(4);
    wr(pcowp_pkg::REG_FLT_CLR, 16'h0000);
    wr(pcowp_pkg::REG_OCD_CFG, 16'h07FF);
    faults(2);
    dsg <= 1'b0;
    chg <= 1'b1;
    cyc(20200);
    rd(pcowp_pkg::REG_STATUS);
    chk({14'h0000, v[5:4]}, 16'h0001);
    chk({14'h0000, fgain}, 16'h0001);
    faults(1);
    report_and_stop();
  end

  initial begin
    #(100_000 * 100);
    n_errors++;
    report_and_stop();
  end
endmodule : tb_pcowp_top
